// File: core/pcmg_pkg.sv
package pcmg_pkg;
	// one octet of a control packet on the link, last marks the final octet
	typedef struct packed {
		logic [7:0] data;
		logic       last;
	} pcmg_beat_type;

	// error report from the checking logic; 16-bit code and octet offset
	typedef struct packed {
		logic [15:0] code;
		logic [15:0] offset;
	} pcmg_err_type;

	// operation type codes
	localparam logic [7:0]  OP_PURGE_REQ   = 8'h05;
	localparam logic [7:0]  OP_PURGE_REPLY = 8'h06;
	localparam logic [7:0]  OP_ERR_IND     = 8'h88;
	localparam logic [15:0] ERR_AUTH_FAIL  = 16'h000b;

	// octet positions counted from the first octet of the fixed header
	localparam int OFS_AFN      = 0;
	localparam int OFS_HOP_CNT  = 9;
	localparam int OFS_PKT_SIZE = 10;
	localparam int OFS_VERSION  = 16;
	localparam int OFS_OP       = 17;
	localparam int OFS_SHTL     = 18;
	localparam int OFS_SSTL     = 19;
	localparam int OFS_SPL      = 20;
	localparam int OFS_DPL      = 21;
	localparam int OFS_FLAGS    = 22;
	localparam int OFS_REQ_ID   = 24;
	localparam int OFS_SRC_NBMA = 28;
	localparam int NOREPLY_BIT  = 7;

	// error indication layout: fixed header, mandatory part, own address only
	localparam int NBMA_LEN    = 20;
	localparam int ERRIND_LEN  = OFS_SRC_NBMA + NBMA_LEN;
	localparam int MIN_REQ_LEN = OFS_REQ_ID;

	// fixed header contents of generated packets
	localparam logic [15:0] ERR_AFN     = 16'h0003;
	localparam logic [7:0]  ERR_HOP_CNT = 8'h01;
	localparam logic [7:0]  NHRP_VER    = 8'h01;
	localparam logic [7:0]  NBMA_TL     = 8'h14;
endpackage : pcmg_pkg

// File: core/pcmg_fifo.sv
// word buffer with a registered output stage; in_ready drops when full
module pcmg_fifo
	import pcmg_pkg::*;
#(
	parameter int WIDTH = 9,
	parameter int DEPTH = 16
) (
	input  wire logic             sys_clk,
	input  wire logic             arst_n,
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  in_ready,
	output logic                  out_valid,
	output logic [WIDTH-1:0]      out_data,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	// pointers wrap naturally, so depth must be a power of two
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
		$error("pcmg_fifo depth must be a power of two");
	end

	logic [WIDTH-1:0] mem [DEPTH];   // storage words
	logic [AW-1:0]    wr_ptr_r;      // next slot to write
	logic [AW-1:0]    rd_ptr_r;      // next slot to read
	logic [CW-1:0]    count_r;       // words held in storage
	logic             push;          // word accepted
	logic             load;          // word moved to output stage

	assign in_ready = (count_r != CW'(DEPTH));
	assign push     = in_valid && in_ready;
	assign load     = (count_r != '0) && (!out_valid || out_ready);

	// storage write, no reset needed on data
	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem[wr_ptr_r] <= in_data;
		end
	end

	// pointers and fill level
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r  <= '0;
		end else begin
			if (push) wr_ptr_r <= wr_ptr_r + AW'(1);
			if (load) rd_ptr_r <= rd_ptr_r + AW'(1);
			count_r <= count_r + CW'(push) - CW'(load);
		end
	end

	// output stage keeps the consumer side straight from flops
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			out_valid <= 1'b0;
			out_data  <= '0;
		end else if (load) begin
			out_valid <= 1'b1;
			out_data  <= mem[rd_ptr_r];
		end else if (out_ready) begin
			out_valid <= 1'b0;
		end
	end
endmodule : pcmg_fifo

// File: core/pcmg_gen.sv
module pcmg_gen
	import pcmg_pkg::*;
#(
	parameter int PKT_MAX    = 256,
	parameter int FIFO_DEPTH = 16
) (
	input  wire logic                  sys_clk,
	input  wire logic                  arst_n,
	input  wire logic                  rx_valid,
	input  wire pcmg_beat_type         rx_beat,
	output logic                       rx_ready,
	input  wire logic                  err_valid,
	input  wire pcmg_err_type          err_info,
	input  wire logic [NBMA_LEN*8-1:0] own_nbma_addr,
	output logic                       tx_valid,
	output pcmg_beat_type              tx_beat,
	input  wire logic                  tx_ready,
	output logic                       pkt_dropped
);
	localparam int IW = $clog2(PKT_MAX);

	// the buffer must at least hold the header fields examined
	if (PKT_MAX < ERRIND_LEN || PKT_MAX > 32768 || (PKT_MAX & (PKT_MAX - 1)) != 0) begin : g_chk
		$error("pcmg_gen packet buffer too small or not a power of two");
	end

	typedef enum logic [1:0] {S_RX, S_DECIDE, S_REPLY, S_ERRIND} pcmg_state_type;

	pcmg_state_type state_r;            // current phase
	logic [7:0]     mem [PKT_MAX];      // received packet store
	logic [15:0]    len_r;              // octets received
	logic [15:0]    rd_r;               // octet index being sent
	logic [7:0]     op_r;               // received op code
	logic           noreply_r;          // received no-reply flag
	logic           ovf_r;              // packet longer than store
	logic           err_seen_r;         // an error was reported
	pcmg_err_type   err_r;              // first reported error
	logic           rx_take;            // octet accepted
	logic           push_valid;         // octet offered to buffer
	pcmg_beat_type  push_beat;          // octet offered to buffer
	logic           push_ready;         // buffer has room
	logic           push;               // octet accepted by buffer
	logic           push_last;          // final octet of outgoing packet
	logic [15:0]    rd_max;             // index of final octet
	logic           reply_ok;           // stored packet qualifies for a purge reply
	logic           drop_now;           // packet discarded this cycle, no answer
	logic           send_done;          // final octet of an answer queued
	logic           pkt_done;           // packet finished either way, state cleared

	// octet of a generated error indication at a given position
	function automatic logic [7:0] errind_byte(input logic [15:0] idx,
			input pcmg_err_type e, input logic [NBMA_LEN*8-1:0] addr);
		int i;
		i = int'(idx);
		if (i >= OFS_SRC_NBMA && i < ERRIND_LEN) begin
			errind_byte = addr[(NBMA_LEN*8-1) - 8*(i-OFS_SRC_NBMA) -: 8];
		end else begin
			unique case (i)
				OFS_AFN:          errind_byte = ERR_AFN[15:8];
				OFS_AFN + 1:      errind_byte = ERR_AFN[7:0];
				OFS_HOP_CNT:      errind_byte = ERR_HOP_CNT;
				OFS_PKT_SIZE + 1: errind_byte = 8'(ERRIND_LEN);
				OFS_VERSION:      errind_byte = NHRP_VER;
				OFS_OP:           errind_byte = OP_ERR_IND;
				OFS_SHTL:         errind_byte = NBMA_TL;
				OFS_SPL:          errind_byte = 8'h00;
				OFS_DPL:          errind_byte = 8'h00;
				OFS_REQ_ID:       errind_byte = e.code[15:8];
				OFS_REQ_ID + 1:   errind_byte = e.code[7:0];
				OFS_REQ_ID + 2:   errind_byte = e.offset[15:8];
				OFS_REQ_ID + 3:   errind_byte = e.offset[7:0];
				default:          errind_byte = 8'h00; // checksum, flags, sstl unused
			endcase
		end
	endfunction : errind_byte

	assign rx_take   = rx_valid && rx_ready;
	assign rd_max    = (state_r == S_ERRIND) ? 16'(ERRIND_LEN - 1) : len_r - 16'd1;
	assign push_last = (rd_r == rd_max);
	assign push      = push_valid && push_ready;

	// decision terms shared by phase control, receive stall and clean-up
	assign reply_ok  = (op_r == OP_PURGE_REQ) && !noreply_r
	                   && (len_r > 16'(MIN_REQ_LEN));
	assign drop_now  = (state_r == S_DECIDE)
	                   && (ovf_r || (err_seen_r ? (op_r == OP_ERR_IND) : !reply_ok));
	assign send_done = (state_r == S_REPLY || state_r == S_ERRIND) && push && push_last;
	// a dropped packet must clear its leftovers too, or the next one would
	// inherit its length, op code and error flag
	assign pkt_done  = drop_now || send_done;

	// outgoing octet selection
	always_comb begin
		push_valid = 1'b0;
		push_beat  = '0;
		if (state_r == S_REPLY) begin
			push_valid     = 1'b1;
			push_beat.data = (rd_r == 16'(OFS_OP)) ? OP_PURGE_REPLY
			                                      : mem[rd_r[IW-1:0]];
			push_beat.last = push_last;
		end else if (state_r == S_ERRIND) begin
			push_valid     = 1'b1;
			push_beat.data = errind_byte(rd_r, err_r, own_nbma_addr);
			push_beat.last = push_last;
		end
	end

	// packet store, write only while receiving
	always_ff @(posedge sys_clk) begin
		if (rx_take && len_r < 16'(PKT_MAX)) begin
			mem[len_r[IW-1:0]] <= rx_beat.data;
		end
	end

	// length and header fields caught on the fly
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			len_r     <= '0;
			op_r      <= '0;
			noreply_r <= 1'b0;
			ovf_r     <= 1'b0;
		end else if (pkt_done) begin
			// a new packet starts clean, whether this one was answered or dropped
			len_r     <= '0;
			op_r      <= '0;
			noreply_r <= 1'b0;
			ovf_r     <= 1'b0;
		end else if (state_r == S_RX && rx_take) begin
			len_r <= len_r + 16'd1;
			if (len_r == 16'(OFS_OP)) op_r <= rx_beat.data;
			if (len_r == 16'(OFS_FLAGS)) noreply_r <= rx_beat.data[NOREPLY_BIT];
			if (len_r >= 16'(PKT_MAX)) ovf_r <= 1'b1;
		end
	end

	// first error of a packet is held, later ones of the same packet ignored
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			err_seen_r <= 1'b0;
			err_r      <= '0;
		end else if (state_r == S_RX && err_valid && !err_seen_r) begin
			// only the first report of a packet is held, so one indication at most
			err_seen_r <= 1'b1;
			err_r      <= err_info;
		end else if (pkt_done) begin
			// reports are taken only while receiving, so the clear never meets a set
			err_seen_r <= 1'b0;
			err_r      <= '0;
		end
	end

	// outgoing index
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rd_r <= '0;
		end else if (push) begin
			rd_r <= push_last ? 16'd0 : rd_r + 16'd1;
		end
	end

	// phase control; the whole packet is held before any decision
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_r     <= S_RX;
			pkt_dropped <= 1'b0;
		end else begin
			pkt_dropped <= 1'b0;
			unique case (state_r)
				S_RX: begin
					if (rx_take && rx_beat.last) state_r <= S_DECIDE;
				end
				S_DECIDE: begin
					if (ovf_r) begin
						state_r     <= S_RX;
						pkt_dropped <= 1'b1;
					end else if (err_seen_r) begin
						// the offending packet is never replayed
						if (op_r == OP_ERR_IND) begin
							state_r     <= S_RX;
							pkt_dropped <= 1'b1;
						end else begin
							state_r <= S_ERRIND;
						end
					end else if (reply_ok) begin
						state_r <= S_REPLY;
					end else begin
						// not ours to answer; dropped and flagged on pkt_dropped
						state_r     <= S_RX;
						pkt_dropped <= 1'b1;
					end
				end
				S_REPLY, S_ERRIND: begin
					if (push && push_last) state_r <= S_RX;
				end
			endcase
		end
	end

	// receive side stalls from the last octet until the answer is queued or the packet is dropped
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rx_ready <= 1'b0;
		end else if (state_r == S_RX) begin
			rx_ready <= !(rx_take && rx_beat.last);
		end else begin
			// reopen once the answer is fully queued or the packet is dropped
			rx_ready <= pkt_done;
		end
	end

	// outgoing buffer; back-pressure stalls replay through push_ready
	pcmg_fifo #(
		.WIDTH ($bits(pcmg_beat_type)),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.sys_clk   (sys_clk),
		.arst_n    (arst_n),
		.in_valid  (push_valid),
		.in_data   (push_beat),
		.in_ready  (push_ready),
		.out_valid (tx_valid),
		.out_data  (tx_beat),
		.out_ready (tx_ready)
	);

	// replayed octets other than the op code equal the stored request
	property p_reply_copy;
		@(posedge sys_clk) disable iff (!arst_n)
		(state_r == S_REPLY && push && rd_r != 16'(OFS_OP))
			|-> push_beat.data == mem[rd_r[IW-1:0]];
	endproperty
	a_reply_copy: assert property (p_reply_copy) else $error("reply octet changed");

	// the one octet that a reply changes
	property p_reply_op;
		@(posedge sys_clk) disable iff (!arst_n)
		(state_r == S_REPLY && push && rd_r == 16'(OFS_OP)) |-> push_beat.data == 8'h06;
	endproperty
	a_reply_op: assert property (p_reply_op) else $error("reply op code wrong");

	// a set no-reply flag never leads to a reply
	property p_noreply;
		@(posedge sys_clk) disable iff (!arst_n)
		(state_r == S_DECIDE && noreply_r) |=> state_r != S_REPLY;
	endproperty
	a_noreply: assert property (p_noreply) else $error("reply despite no-reply");

	// indication op code in the fixed header
	property p_err_op;
		@(posedge sys_clk) disable iff (!arst_n)
		(state_r == S_ERRIND && push && rd_r == 16'd17) |-> push_beat.data == 8'h88;
	endproperty
	a_err_op: assert property (p_err_op) else $error("error op code wrong");

	// code leads the request id field
	property p_err_code;
		@(posedge sys_clk) disable iff (!arst_n)
		(state_r == S_ERRIND && push && rd_r == 16'd24)
			|-> push_beat.data == err_r.code[15:8];
	endproperty
	a_err_code: assert property (p_err_code) else $error("code not in upper half");

	// both protocol addresses are left out, so their lengths are zero
	property p_err_lens;
		@(posedge sys_clk) disable iff (!arst_n)
		(state_r == S_ERRIND && push && (rd_r == 16'd20 || rd_r == 16'd21))
			|-> push_beat.data == 8'h00;
	endproperty
	a_err_lens: assert property (p_err_lens) else $error("protocol length not zero");

	// an incoming indication is never answered at all
	property p_no_err_for_err;
		@(posedge sys_clk) disable iff (!arst_n)
		(state_r == S_DECIDE && op_r == OP_ERR_IND) |=> state_r == S_RX;
	endproperty
	a_no_err_for_err: assert property (p_no_err_for_err) else $error("answered error ind");

	// a faulty packet is never replayed as a reply
	property p_discard;
		@(posedge sys_clk) disable iff (!arst_n)
		(state_r == S_DECIDE && err_seen_r) |=> state_r != S_REPLY;
	endproperty
	a_discard: assert property (p_discard) else $error("offending packet replayed");

	// an indication is exactly the fixed length and ends the error state
	property p_one_errind;
		@(posedge sys_clk) disable iff (!arst_n)
		(state_r == S_ERRIND && push && push_last)
			|-> rd_r == 16'd47 ##1 (state_r == S_RX && !err_seen_r);
	endproperty
	a_one_errind: assert property (p_one_errind) else $error("error ind length or repeat");

	// the own address leads the source address field of an indication
	property p_err_addr;
		@(posedge sys_clk) disable iff (!arst_n)
		(state_r == S_ERRIND && push && rd_r == 16'(OFS_SRC_NBMA))
			|-> push_beat.data == own_nbma_addr[NBMA_LEN*8-1 -: 8];
	endproperty
	a_err_addr: assert property (p_err_addr) else $error("source address wrong");

	// size field covers header and own address only, nothing appended
	property p_err_size;
		@(posedge sys_clk) disable iff (!arst_n)
		(state_r == S_ERRIND && push && rd_r == 16'(OFS_PKT_SIZE + 1))
			|-> push_beat.data == 8'(ERRIND_LEN);
	endproperty
	a_err_size: assert property (p_err_size) else $error("indication size wrong");

	// offset closes the request id field
	property p_err_ofs;
		@(posedge sys_clk) disable iff (!arst_n)
		(state_r == S_ERRIND && push && rd_r == 16'(OFS_REQ_ID + 3))
			|-> push_beat.data == err_r.offset[7:0];
	endproperty
	a_err_ofs: assert property (p_err_ofs) else $error("offset not in lower half");

	// nothing of a finished packet survives into the next one
	property p_fresh_pkt;
		@(posedge sys_clk) disable iff (!arst_n)
		pkt_done |=> (len_r == 16'd0 && !err_seen_r && state_r == S_RX);
	endproperty
	a_fresh_pkt: assert property (p_fresh_pkt) else $error("packet state left over");

	// every discarded packet is reported on the drop pulse
	property p_drop_pulse;
		@(posedge sys_clk) disable iff (!arst_n)
		drop_now |=> pkt_dropped;
	endproperty
	a_drop_pulse: assert property (p_drop_pulse) else $error("drop not reported");
endmodule : pcmg_gen

// File: tb/pcmg_peer.sv
// far-side consumer of the control channel; collects each outgoing packet
module pcmg_peer
	import pcmg_pkg::*;
(
	input  wire logic          sys_clk,
	input  wire logic          arst_n,
	input  wire logic          slow,
	input  wire logic          tx_valid,
	input  wire pcmg_beat_type tx_beat,
	output logic               tx_ready
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [7:0] pkt [0:511]; // octets of the current or last packet
	int         cnt;         // octets taken of the current packet
	int         len;         // length of the last finished packet
	int         npkt;        // finished packets
	logic [1:0] ph;          // stall phase

	// slow takes one octet in four, so the fifo backs up behind us
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			tx_ready <= 1'b0;
			ph <= 2'h0;
			cnt <= 0;
			len <= 0;
			npkt <= 0;
		end else begin
			ph <= ph + 2'h1;
			tx_ready <= slow ? (ph == 2'h3) : 1'b1;
			if (tx_valid && tx_ready) begin
				pkt[cnt[8:0]] <= tx_beat.data;
				cnt <= tx_beat.last ? 0 : cnt + 1;
				if (tx_beat.last) begin
					len <= cnt + 1;
					npkt <= npkt + 1;
				end
			end
		end
	end
endmodule : pcmg_peer

// File: tb/pcmg_gen_tb_top.sv
// table-driven bench: each row is one received packet and its outcome
module pcmg_gen_tb_top
	import pcmg_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	// kind: 0 dropped, 1 purge reply, 2 error indication
	typedef struct {
		logic [7:0]  op;
		logic        nrep;
		int          len;
		int          e1;
		int          e2;
		logic [15:0] code;
		logic [15:0] ofs;
		logic        slow;
		int          kind;
	} pcmg_row_type;

	localparam int NROW = 9;

	logic                  sys_clk       = 1'b0;
	logic                  arst_n        = 1'b0;
	logic                  rx_valid      = 1'b0;
	pcmg_beat_type         rx_beat       = '0;
	logic                  err_valid     = 1'b0;
	pcmg_err_type          err_info      = '0;
	logic [NBMA_LEN*8-1:0] own_nbma_addr = '0;
	logic                  slow          = 1'b0;
	logic                  rx_ready;
	logic                  tx_valid;
	logic                  tx_ready;
	pcmg_beat_type         tx_beat;
	logic                  pkt_dropped;
	int                    mismatches    = 0;
	int                    total_checks  = 0;
	int                    cycles        = 0;
	pcmg_row_type          rows [NROW];

	always #25 sys_clk = ~sys_clk;

	pcmg_gen #(.PKT_MAX(256), .FIFO_DEPTH(16)) u_dut (
		.sys_clk(sys_clk), .arst_n(arst_n), .rx_valid(rx_valid), .rx_beat(rx_beat),
		.rx_ready(rx_ready), .err_valid(err_valid), .err_info(err_info),
		.own_nbma_addr(own_nbma_addr), .tx_valid(tx_valid), .tx_beat(tx_beat),
		.tx_ready(tx_ready), .pkt_dropped(pkt_dropped));

	pcmg_peer u_peer (
		.sys_clk(sys_clk), .arst_n(arst_n), .slow(slow), .tx_valid(tx_valid),
		.tx_beat(tx_beat), .tx_ready(tx_ready));

	task automatic summarize();
		if (mismatches == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : summarize

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : chk

	// request content: a running pattern, with op code and flags placed
	function automatic logic [7:0] src_byte(pcmg_row_type r, int i);
		if (i == OFS_OP) return r.op;
		if (i == OFS_FLAGS) return {r.nrep, 7'h00};
		return 8'(i) ^ 8'h5a;
	endfunction : src_byte

	// error indication octets worked out field by field
	function automatic logic [7:0] err_byte(pcmg_row_type r, int i);
		case (i)
			0:       return ERR_AFN[15:8];
			1:       return ERR_AFN[7:0];
			9:       return ERR_HOP_CNT;
			10:      return 8'(ERRIND_LEN >> 8);
			11:      return 8'(ERRIND_LEN);
			16:      return NHRP_VER;
			17:      return OP_ERR_IND;
			18:      return NBMA_TL;
			24:      return r.code[15:8];
			25:      return r.code[7:0];
			26:      return r.ofs[15:8];
			27:      return r.ofs[7:0];
			default: return (i < OFS_SRC_NBMA) ? 8'h00 :
				8'ha0 + 8'(i - OFS_SRC_NBMA); // own address octets as set up below
		endcase
	endfunction : err_byte

	// octets offered back to back; held until rx_ready is seen high
	task automatic send(input pcmg_row_type r);
		for (int i = 0; i < r.len; i++) begin
			@(negedge sys_clk);
			rx_valid = 1'b1;
			rx_beat = '{data: src_byte(r, i), last: (i == r.len - 1)};
			err_valid = (i == r.e1) || (i == r.e2);
			err_info = '{code: r.code + 16'(i == r.e2), offset: r.ofs};
			for (int w = 0; w < 500 && rx_ready !== 1'b1; w++) @(negedge sys_clk);
		end
		@(negedge sys_clk);
		rx_valid = 1'b0;
		err_valid = 1'b0;
	endtask : send

	task automatic run(input pcmg_row_type r);
		int n0;
		int drop;
		int n;
		n0 = u_peer.npkt;
		drop = 0;
		slow = r.slow;
		send(r);
		for (int w = 0; w < 2000 && drop == 0 && u_peer.npkt == n0; w++) begin
			@(negedge sys_clk);
			if (pkt_dropped === 1'b1) drop = 1;
		end
		// a late answer after a drop would still show up here
		repeat (60) @(negedge sys_clk);
		chk(16'(drop), 16'(r.kind == 0), "drop pulse");
		chk(16'(u_peer.npkt - n0), 16'(r.kind != 0), "answers");
		n = (r.kind == 1) ? r.len : ERRIND_LEN;
		if (r.kind == 1) chk(16'(u_peer.len), 16'(n), "reply length");
		if (r.kind == 2) chk(16'(u_peer.len), 16'(n), "indication length");
		for (int i = 0; i < n && r.kind != 0; i++) begin
			if (r.kind == 1) begin
				chk(u_peer.pkt[i], (i == OFS_OP) ? OP_PURGE_REPLY : src_byte(r, i), "reply");
			end else begin
				chk(u_peer.pkt[i], err_byte(r, i), "indication");
			end
		end
	endtask : run

	// cuts a hang short
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			summarize();
		end
	end

	initial begin
		rows = '{
			'{8'h05, 1'b0, 40, -1, -1, 16'h0000, 16'h0000, 1'b0, 1},
			'{8'h05, 1'b1, 40, -1, -1, 16'h0000, 16'h0000, 1'b0, 0},
			'{8'h06, 1'b0, 40, -1, -1, 16'h0000, 16'h0000, 1'b0, 0},
			'{8'h05, 1'b0, 40, 39, -1, 16'h000b, 16'h0027, 1'b1, 2},
			'{8'h88, 1'b0, 48, 5, -1, 16'h000b, 16'h0005, 1'b0, 0},
			'{8'h05, 1'b0, 60, 3, 10, 16'h000b, 16'h0003, 1'b0, 2},
			'{8'h05, 1'b0, 25, -1, -1, 16'h0000, 16'h0000, 1'b1, 1},
			'{8'h05, 1'b0, 24, -1, -1, 16'h0000, 16'h0000, 1'b0, 0},
			'{8'h05, 1'b0, 257, -1, -1, 16'h0000, 16'h0000, 1'b0, 0}};
		// own address octet k is 8'ha0 plus k, first octet on top
		for (int k = 0; k < NBMA_LEN; k++) own_nbma_addr[(NBMA_LEN - k) * 8 - 1 -: 8] = 8'ha0 + 8'(k);
		repeat (10) @(negedge sys_clk);
		chk(16'(rx_ready), 16'h0000, "rx_ready in reset");
		chk(16'(tx_valid), 16'h0000, "tx_valid in reset");
		chk(16'(pkt_dropped), 16'h0000, "pkt_dropped in reset");
		chk(16'(tx_beat), 16'h0000, "tx_beat in reset");
		arst_n = 1'b1;
		@(negedge sys_clk);
		chk(16'(rx_ready), 16'h0001, "rx_ready after reset");
		for (int r = 0; r < NROW; r++) run(rows[r]);
		summarize();
	end
endmodule : pcmg_gen_tb_top
